// *** bench/sac_adc_ctrl_checker.sv ***
// Bound checker for the converter control ports.
`timescale 1ns/1ps
module sac_adc_ctrl_checker (
    input wire logic                  hclk,
    input wire logic                  hresetn,
    input wire logic                  hsel,
    input wire logic [31:0]           haddr,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic                  hready,
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input wire logic                  stop_mode,
    input wire logic [4:0]            mux_sel,
    input wire logic                  analog_pwr,
    input wire sac_pkg::sac_pin_ctl_t pin_ctl,
    input wire logic                  conv_irq,
    input wire logic                  wake_req
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Accepted address phases that touch control or result words.
    sequence wr_scr;
        hsel && hready && htrans[1] && hwrite
            && haddr[7:0] == sac_pkg::ADDR_SCR;
    endsequence
    sequence rd_res;
        hsel && hready && htrans[1] && !hwrite
            && (haddr[7:0] == sac_pkg::ADDR_RESH
            || haddr[7:0] == sac_pkg::ADDR_RESL);
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answered with wait or error");
    a_pin_claimed: assert property (
        mux_sel <= 5'h07 && $stable(mux_sel) && !stop_mode
        |-> pin_ctl.analog_sel == (8'h01 << mux_sel))
        else $error("selected pin not claimed as analog");
    a_mask_matches: assert property (
        $stable(mux_sel) |-> pin_ctl.read_mask == ~pin_ctl.analog_sel)
        else $error("digital read mask disagrees with claim");
    a_off_unpowered: assert property (
        (mux_sel == sac_pkg::CH_OFF) [*2] |-> !analog_pwr)
        else $error("analog powered on the off channel");
    a_stop_unpowered: assert property (
        stop_mode [*2] |-> !analog_pwr)
        else $error("analog powered during stop");
    a_irq_write_drop: assert property (
        wr_scr |-> ##[1:2] !conv_irq)
        else $error("request kept after control write");
    a_irq_read_drop: assert property (
        rd_res |-> ##[1:3] !conv_irq)
        else $error("request kept after result read");
    a_wake_pulse: assert property (
        wake_req |=> !wake_req)
        else $error("wake request longer than one cycle");
    a_wake_from_irq: assert property (
        wake_req |-> ##[0:1] conv_irq)
        else $error("wake request without converter request");
endmodule
bind sac_adc_ctrl sac_adc_ctrl_checker u_chk (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .stop_mode(stop_mode), .mux_sel(mux_sel),
    .analog_pwr(analog_pwr), .pin_ctl(pin_ctl), .conv_irq(conv_irq),
    .wake_req(wake_req));

// *** bench/sac_adc_ctrl_tb.sv ***
// Self-checking bench for the converter control.
`timescale 1ns/1ps
module sac_adc_ctrl_tb;
    localparam logic [7:0] A_SCR = sac_pkg::ADDR_SCR;
    localparam logic [7:0] A_H = sac_pkg::ADDR_RESH;
    localparam logic [7:0] A_L = sac_pkg::ADDR_RESL;
    localparam logic [7:0] A_CLK = sac_pkg::ADDR_CLK;
    localparam logic [7:0] A_ST = sac_pkg::ADDR_STAT;
    localparam logic [9:0] LV3 = 10'h1b5;
    logic        hclk, hresetn, hsel, hwrite, hresp, hreadyout;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        stop_mode, wait_mode, cmp_above, analog_pwr;
    logic        conv_irq, wake_req, wake_seen, alt_en;
    logic [9:0]  dac_code;
    logic [4:0]  mux_sel;
    sac_pkg::sac_pin_ctl_t pin_ctl;
    int          n_fail, tests_run;
    sac_adc_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .alt_clk_en(alt_en),
        .stop_mode(stop_mode), .wait_mode(wait_mode),
        .cmp_above(cmp_above), .dac_code(dac_code), .mux_sel(mux_sel),
        .analog_pwr(analog_pwr), .pin_ctl(pin_ctl),
        .conv_irq(conv_irq), .wake_req(wake_req));
    sac_analog_model u_ana (.hclk(hclk), .mux_sel(mux_sel),
        .dac_code(dac_code), .analog_pwr(analog_pwr),
        .cmp_above(cmp_above));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // The wake pulse lasts one cycle, so it is latched for later judging.
    always @(posedge hclk) begin
        if (!hresetn) begin
            wake_seen <= 1'b0;
        end else if (wake_req === 1'b1) begin
            wake_seen <= 1'b1;
        end
    end
    // Alternate converter clock source: an enable on every second cycle.
    always @(posedge hclk) alt_en <= hresetn ? ~alt_en : 1'b0;
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Bounded wait for an edge with the slave ready.
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            @(posedge hclk);
            n++;
        end
        if (hreadyout !== 1'b1) n_fail++;
    endtask
    // One single-word transfer; read data lands in rdv.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rdv = hrdata;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rdv, exp);
    endtask
    // Polls one bit until it reaches v; a bounded number of reads.
    task automatic poll(input logic [7:0] a, input int b, input logic v);
        int n;
        n = 0;
        bus(1'b0, a, 32'h0);
        while (rdv[b] !== v && n < 200) begin
            bus(1'b0, a, 32'h0);
            n++;
        end
        check({31'h0, rdv[b]}, {31'h0, v});
    endtask
    // k is the number of bus cycles per converter clock tick.
    task automatic convert(input logic [31:0] scr, input int k);
        realtime t0;
        bus(1'b1, A_SCR, scr);
        t0 = $realtime;
        poll(A_ST, 0, 1'b0);
        check(($realtime - t0) / 10 inside {[14*k:22*k]}, 32'h1);
    endtask
    task automatic t_reset;
        chk_rd(A_SCR, 32'h1f);
        chk_rd(A_CLK, 32'h0);
        chk_rd(8'h20, 32'h0);
        check({31'h0, analog_pwr}, 32'h0);
        convert(32'h03, 2);
    endtask
    task automatic t_formats;
        logic [31:0] h, l;
        for (int f = 0; f < 4; f++) begin
            h = {24'h0, LV3[9:2]};
            l = {24'h0, LV3[1:0], 6'h0};
            if (f == 1) begin
                h = {30'h0, LV3[9:8]};
                l = {24'h0, LV3[7:0]};
            end
            if (f == 2) h[7] = ~LV3[9];
            if (f == 3) l = {24'h0, LV3[9:2]};
            bus(1'b1, A_CLK, 32'h10 | (f << 2));
            convert(32'h03, 1);
            chk_rd(A_SCR, 32'h83);
            check({16'h0, pin_ctl}, 32'h08f7);
            if (f != 3) chk_rd(A_H, h);
            chk_rd(A_L, l);
            chk_rd(A_SCR, 32'h03);
        end
    endtask
    task automatic t_irq;
        int n;
        n = 0;
        wait_mode <= 1'b1;
        bus(1'b1, A_SCR, 32'h43);
        while (conv_irq !== 1'b1 && n < 100) begin
            @(posedge hclk);
            n++;
        end
        @(posedge hclk);
        check({31'h0, conv_irq}, 32'h1);
        check({31'h0, wake_seen}, 32'h1);
        chk_rd(A_SCR, 32'h43);
        chk_rd(A_L, {24'h0, LV3[9:2]});
        @(posedge hclk);
        check({31'h0, conv_irq}, 32'h0);
        wait_mode <= 1'b0;
    endtask
    task automatic t_cont;
        bus(1'b1, A_CLK, 32'h14);
        bus(1'b1, A_SCR, 32'h3d);
        poll(A_SCR, 7, 1'b1);
        chk_rd(A_H, 32'h3);
        chk_rd(A_L, 32'hff);
        poll(A_SCR, 7, 1'b1);
        chk_rd(A_H, 32'h3);
        // Locked by the high read: the next result must not land.
        bus(1'b1, A_SCR, 32'h3e);
        poll(A_SCR, 7, 1'b1);
        chk_rd(A_L, 32'hff);
        poll(A_SCR, 7, 1'b1);
        chk_rd(A_H, 32'h0);
        chk_rd(A_L, 32'h0);
        bus(1'b1, A_SCR, 32'h1e);
        poll(A_ST, 0, 1'b0);
        repeat (40) @(posedge hclk);
        bus(1'b0, A_ST, 32'h0);
        check({31'h0, rdv[0]}, 32'h0);
    endtask
    task automatic t_stop;
        bus(1'b0, A_L, 32'h0);
        bus(1'b1, A_SCR, 32'h03);
        repeat (4) @(posedge hclk);
        stop_mode <= 1'b1;
        repeat (4) @(posedge hclk);
        check({31'h0, analog_pwr}, 32'h0);
        bus(1'b0, A_ST, 32'h0);
        check({31'h0, rdv[0]}, 32'h0);
        stop_mode <= 1'b0;
        // The aborted result is never read; the first run only settles.
        convert(32'h03, 1);
        chk_rd(A_SCR, 32'h03);
        bus(1'b1, A_CLK, 32'h34);
        convert(32'h03, 2);
        chk_rd(A_SCR, 32'h83);
        chk_rd(A_L, {24'h0, LV3[7:0]});
    endtask
    // Cuts a hang short well past the expected run length.
    initial begin
        #100us;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        {hsel, hwrite, stop_mode, wait_mode} = 4'h0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        hsize = 3'h2;
        hresetn = 1'b0;
        n_fail = 0;
        tests_run = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_formats();
        t_irq();
        t_cont();
        t_stop();
        tally_and_finish();
    end
endmodule

// *** bench/sac_analog_model.sv ***
// Analog side model: comparator fed by eight fixed pin levels.
`timescale 1ns/1ps
module sac_analog_model (
    input  wire logic       hclk,
    input  wire logic [4:0] mux_sel,
    input  wire logic [9:0] dac_code,
    input  wire logic       analog_pwr,
    output logic            cmp_above
);
    logic       tgl;
    logic [9:0] level;
    // Pin level carries the channel index in its top bits.
    assign level = {mux_sel[2:0], 7'h35};
    // Unpowered or off-pin, a toggling answer so no stale level is trusted.
    initial tgl = 1'b0;
    always @(posedge hclk) tgl <= ~tgl;
    assign cmp_above = (analog_pwr && mux_sel <= 5'h07)
        ? (level >= dac_code) : tgl;
endmodule

// *** hw/sac_adc_ctrl.sv ***
// Successive-approximation converter control with AHB-Lite registers.
`timescale 1ns/1ps
// How it works
// - Rails map to 3ff and 000 linearly.
// - Status/control write starts conversion unless it selects the off channel.
// - Conversion takes seventeen converter clock cycles.
// - Continuous mode overwrites result every conversion while not locked.
// - Continuous mode restarts until bit cleared.
// - Complete flag set, cleared by data read.
// - Single mode converts once per write.
// - Selected pin forced to analog input.
// - Digital read of selected pin gives zero.
// - Unselected pins stay general-purpose I/O.
// - Two-bit format field picks four formats.
// - Left format: eight MSBs high, two low.
// - High read locks low until low read.
// - Right format: two MSBs high, eight low.
// - Signed format inverts result top bit.
// - Truncation: eight MSBs in low, no lock.
// - Interrupt enable raises request per conversion.
// - Wait mode converts; interrupt ends wait.
// - Stop aborts conversion, settle conversion after.
// - All-ones channel powers off, settle after.
// - Channel codes select pins and references.
// - With interrupt enable, complete flag reads 0.
// - Data read or control write drops request.
module sac_adc_ctrl #(
    parameter int RES_BITS = 10,
    parameter int DIV_W    = 3
) (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic [31:0]              hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire logic                alt_clk_en,
    input  wire logic                stop_mode,
    input  wire logic                wait_mode,
    input  wire logic                cmp_above,
    output logic [RES_BITS-1:0]      dac_code,
    output logic [4:0]               mux_sel,
    output logic                     analog_pwr,
    output sac_pkg::sac_pin_ctl_t    pin_ctl,
    output logic                     conv_irq,
    output logic                     wake_req
);
    localparam logic [RES_BITS-1:0] TOP_BIT = RES_BITS'(1) << (RES_BITS - 1);

    // Bus address phase capture.
    logic       wr_pend_q;
    logic       rd_pend_q;
    logic [7:0] addr_q;
    logic       acc;
    assign acc = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 8'h00;
        end else begin
            wr_pend_q <= acc && hwrite;
            rd_pend_q <= acc && !hwrite;
            if (acc) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    // Always zero-wait, always OKAY; unmapped reads return zero.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    logic scr_wr;
    logic clk_wr;
    logic rdh_ev;
    logic rdl_ev;
    assign scr_wr = wr_pend_q && addr_q == sac_pkg::ADDR_SCR;
    assign clk_wr = wr_pend_q && addr_q == sac_pkg::ADDR_CLK;
    // Read events are decoded in the address phase so data is ready.
    assign rdh_ev = acc && !hwrite && haddr[7:0] == sac_pkg::ADDR_RESH;
    assign rdl_ev = acc && !hwrite && haddr[7:0] == sac_pkg::ADDR_RESL;

    // Control registers.
    logic       irq_en_q;
    logic       cont_q;
    logic [4:0] chan_q;
    logic [7:0] clkreg_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_en_q <= 1'b0;
            cont_q   <= 1'b0;
            chan_q   <= sac_pkg::CH_RESET;
        end else if (scr_wr) begin
            irq_en_q <= hwdata[sac_pkg::SCR_IRQEN_BIT];
            cont_q   <= hwdata[sac_pkg::SCR_CONT_BIT];
            chan_q   <= hwdata[4:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clkreg_q <= sac_pkg::CLK_RESET;
        end else if (clk_wr) begin
            clkreg_q <= hwdata[7:0];
        end
    end

    sac_pkg::sac_fmt_t fmt;
    logic [DIV_W-1:0]  div_sel;
    assign fmt     = sac_pkg::sac_fmt_t'(clkreg_q[sac_pkg::CLK_FMT_LSB +: 2]);
    assign div_sel = clkreg_q[sac_pkg::CLK_DIV_LSB +: DIV_W];

    // Converter clock tick: bus clock or alternate source, divided by
    // two to the power of the divider field.  A tick is a one-cycle
    // enable, so the whole block stays on one clock.
    logic [7:0] pre_q;
    logic       src_tick;
    logic       tick;
    assign src_tick = clkreg_q[sac_pkg::CLK_SRC_BIT] ? 1'b1 : alt_clk_en;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q <= 8'h00;
        end else if (src_tick) begin
            pre_q <= pre_q + 8'h01;
        end
    end
    logic [7:0] div_mask;
    assign div_mask = 8'((9'h001 << div_sel) - 9'h001);
    assign tick = src_tick && ((pre_q & div_mask) == div_mask);

    // Sequencer.
    sac_pkg::sac_state_t st_q;
    logic [4:0]          cyc_q;
    logic [RES_BITS-1:0] sar_q;
    logic [RES_BITS-1:0] trial_q;
    logic                settle_q;
    logic                powered;
    logic                done_ev;
    assign powered = chan_q != sac_pkg::CH_OFF;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q     <= sac_pkg::SAC_IDLE;
            cyc_q    <= 5'h00;
            sar_q    <= '0;
            trial_q  <= '0;
            settle_q <= 1'b1;
        end else if (stop_mode) begin
            // Abort and mark the analog side as needing one settle conversion.
            st_q     <= sac_pkg::SAC_IDLE;
            settle_q <= 1'b1;
        end else if (scr_wr) begin
            // A new write restarts; old partial data is simply dropped.
            // The written channel decides, since chan_q still holds the
            // previous one here and may be the off code after reset.
            if (hwdata[4:0] == sac_pkg::CH_OFF) begin
                st_q <= sac_pkg::SAC_IDLE;
            end else begin
                st_q <= sac_pkg::SAC_SAMPLE;
            end
            cyc_q <= 5'h00;
        end else if (!powered) begin
            // Power-off: stay idle, and the next conversion only settles.
            st_q     <= sac_pkg::SAC_IDLE;
            settle_q <= 1'b1;
        end else if (tick) begin
            case (st_q)
                sac_pkg::SAC_IDLE: begin
                    // Resume after stop with a settle conversion first.
                    if (cont_q) begin
                        st_q  <= sac_pkg::SAC_SAMPLE;
                        cyc_q <= 5'h00;
                    end
                end
                sac_pkg::SAC_SAMPLE: begin
                    cyc_q   <= cyc_q + 5'h01;
                    sar_q   <= '0;
                    trial_q <= TOP_BIT;
                    st_q    <= sac_pkg::SAC_TRIAL;
                end
                sac_pkg::SAC_TRIAL: begin
                    cyc_q <= cyc_q + 5'h01;
                    if (trial_q != '0) begin
                        // Keep the bit when the input is at or above it.
                        if (cmp_above) begin
                            sar_q <= sar_q | trial_q;
                        end
                        trial_q <= trial_q >> 1;
                    end else if (cyc_q == sac_pkg::CONV_LAST) begin
                        st_q <= sac_pkg::SAC_DONE;
                    end
                end
                sac_pkg::SAC_DONE: begin
                    settle_q <= 1'b0;
                    cyc_q    <= 5'h00;
                    st_q     <= cont_q ? sac_pkg::SAC_SAMPLE
                                       : sac_pkg::SAC_IDLE;
                end
                default: st_q <= sac_pkg::SAC_IDLE;
            endcase
        end
    end

    // Completion is one bus cycle, never during a settle conversion.
    assign done_ev = tick && st_q == sac_pkg::SAC_DONE && !settle_q
                     && !stop_mode && powered && !scr_wr;

    // Reference channels are resolved digitally to the rail codes.
    logic [RES_BITS-1:0] result;
    always_comb begin
        result = sar_q;
        if (chan_q == sac_pkg::CH_REFH) begin
            result = sac_pkg::CODE_FULL;
        end else if (chan_q == sac_pkg::CH_REFL) begin
            result = sac_pkg::CODE_ZERO;
        end
    end

    // Formatting and the high/low interlock.
    logic [7:0] resh_q;
    logic [7:0] resl_q;
    logic       lock_q;
    logic [7:0] fh;
    logic [7:0] fl;
    always_comb begin
        case (fmt)
            sac_pkg::SAC_FMT_LEFT: begin
                fh = result[9:2];
                fl = {result[1:0], 6'h00};
            end
            sac_pkg::SAC_FMT_RIGHT: begin
                fh = {6'h00, result[9:8]};
                fl = result[7:0];
            end
            sac_pkg::SAC_FMT_LSIGNED: begin
                fh = {~result[9], result[8:2]};
                fl = {result[1:0], 6'h00};
            end
            default: begin
                fh = 8'h00;
                fl = result[9:2];
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            resh_q <= 8'h00;
            resl_q <= 8'h00;
        end else if (done_ev && !lock_q) begin
            resh_q <= fh;
            resl_q <= fl;
        end
    end

    // Reading high locks until low is read; truncation never locks.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_q <= 1'b0;
        end else if (fmt == sac_pkg::SAC_FMT_TRUNC8) begin
            lock_q <= 1'b0;
        end else if (rdl_ev) begin
            lock_q <= 1'b0;
        end else if (rdh_ev) begin
            lock_q <= 1'b1;
        end
    end

    // Complete flag and interrupt: the set wins over a same-cycle clear.
    logic complete_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            complete_q <= 1'b0;
            conv_irq   <= 1'b0;
        end else begin
            if (irq_en_q) begin
                complete_q <= 1'b0;
            end else if (done_ev) begin
                complete_q <= 1'b1;
            end else if (rdh_ev || rdl_ev) begin
                complete_q <= 1'b0;
            end
            if (done_ev && irq_en_q) begin
                conv_irq <= 1'b1;
            end else if (rdh_ev || rdl_ev || scr_wr) begin
                conv_irq <= 1'b0;
            end
        end
    end

    // Wake request follows the interrupt only while waiting.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= wait_mode && done_ev && irq_en_q;
        end
    end

    // Code the comparator judges next.  Registering the present code
    // instead would leave the comparator one trial behind whenever the
    // converter clock ticks on every bus cycle.
    logic [RES_BITS-1:0] code_d;
    always_comb begin
        code_d = sar_q | trial_q;
        if (tick && !stop_mode && powered && !scr_wr) begin
            if (st_q == sac_pkg::SAC_SAMPLE) begin
                code_d = TOP_BIT;
            end else if (st_q == sac_pkg::SAC_TRIAL && trial_q != '0) begin
                code_d = (cmp_above ? (sar_q | trial_q) : sar_q)
                         | (trial_q >> 1);
            end
        end
    end

    // Analog side outputs.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dac_code   <= '0;
            mux_sel    <= sac_pkg::CH_RESET;
            analog_pwr <= 1'b0;
        end else begin
            dac_code   <= code_d;
            mux_sel    <= chan_q;
            analog_pwr <= powered && !stop_mode;
        end
    end

    // Pin takeover: only the selected port pin is claimed.
    for (genvar i = 0; i < sac_pkg::NUM_PINS; i++) begin : g_pin
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pin_ctl.analog_sel[i] <= 1'b0;
                pin_ctl.read_mask[i]  <= 1'b1;
            end else begin
                pin_ctl.analog_sel[i] <= chan_q == 5'(i);
                pin_ctl.read_mask[i]  <= chan_q != 5'(i);
            end
        end
    end

    // Read data mux registered in the address phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (acc && !hwrite) begin
            case (haddr[7:0])
                sac_pkg::ADDR_SCR: hrdata <= {24'h000000,
                    complete_q && !irq_en_q, irq_en_q, cont_q, chan_q};
                sac_pkg::ADDR_RESH: hrdata <= {24'h000000, resh_q};
                sac_pkg::ADDR_RESL: hrdata <= {24'h000000, resl_q};
                sac_pkg::ADDR_CLK:  hrdata <= {24'h000000, clkreg_q};
                sac_pkg::ADDR_STAT: hrdata <= {29'h00000000, lock_q,
                    settle_q, st_q != sac_pkg::SAC_IDLE};
                default:            hrdata <= 32'h0000_0000;
            endcase
        end
    end

    logic unused;
    assign unused = ^{hsize, haddr[31:8], rd_pend_q, hwdata[31:8]};
endmodule

// *** shared/sac_pkg.sv ***
// Package holding register map, field layout and types of the converter control.
package sac_pkg;
    // Register byte addresses on the AHB-Lite bus.
    localparam logic [7:0] ADDR_SCR    = 8'h00;
    localparam logic [7:0] ADDR_RESH   = 8'h04;
    localparam logic [7:0] ADDR_RESL   = 8'h08;
    localparam logic [7:0] ADDR_CLK    = 8'h0c;
    localparam logic [7:0] ADDR_STAT   = 8'h10;
    // Status/control field positions.
    localparam int SCR_COMPLETE_BIT = 7;
    localparam int SCR_IRQEN_BIT    = 6;
    localparam int SCR_CONT_BIT     = 5;
    localparam logic [4:0] CH_RESET   = 5'h1f;
    localparam logic [4:0] CH_OFF     = 5'h1f;
    localparam logic [4:0] CH_REFH    = 5'h1d;
    localparam logic [4:0] CH_REFL    = 5'h1e;
    localparam logic [4:0] CH_LAST_PIN = 5'h07;
    // Clock register field positions: divider 7:5, source 4, format 3:2.
    localparam int CLK_DIV_LSB  = 5;
    localparam int CLK_SRC_BIT  = 4;
    localparam int CLK_FMT_LSB  = 2;
    localparam logic [7:0] CLK_RESET = 8'h00;
    // Result codes at the reference rails.
    localparam logic [9:0] CODE_FULL = 10'h3ff;
    localparam logic [9:0] CODE_ZERO = 10'h000;
    // Sequence length: sample cycle plus ten bit trials plus settle cycles.
    localparam int CONV_CYCLES = 16;
    localparam logic [4:0] CONV_LAST = 5'(CONV_CYCLES - 1);
    localparam int NUM_PINS = 8;
    typedef enum logic [1:0] {
        SAC_FMT_LEFT,
        SAC_FMT_RIGHT,
        SAC_FMT_LSIGNED,
        SAC_FMT_TRUNC8
    } sac_fmt_t;
    typedef enum {
        SAC_IDLE,
        SAC_SAMPLE,
        SAC_TRIAL,
        SAC_DONE
    } sac_state_t;
    // Port pin control handed back to general-purpose I/O logic.
    typedef struct packed {
        logic [7:0] analog_sel;
        logic [7:0] read_mask;
    } sac_pin_ctl_t;
endpackage
